//--- dv/hssc_asserts.sv
// Port checker for the high-side switch control block
`timescale 1ns/1ns
`default_nettype none

module hssc_asserts
#(
  parameter int WAKE_FILTER_CYCLES = 4
)
(
  // Clock and reset
  input wire logic       CLOCK,
  input wire logic       RST,
  // Watched inputs
  input wire logic       RESTART_ENTRY,
  input wire logic       SPI_CSN,
  input wire logic [3:0] SWITCH_FAULT,
  input wire logic [1:0] PIN_LEVEL,
  // Watched outputs
  input wire logic       SPI_SDO_OE,
  input wire logic [3:0] HIGH_SWITCH_DRIVE,
  input wire logic       PULSE_CHANNEL_ONE,
  input wire logic [1:0] PIN_FAIL_SELECT,
  input wire logic [1:0] PIN_LOW_SIDE_ON,
  input wire logic [1:0] PIN_HIGH_SIDE_ON,
  input wire logic [1:0] PIN_WAKE_ENABLE,
  input wire logic [1:0] WAKE_EVENT
);
  // ------------------------------------------------
  // Helper history
  // ------------------------------------------------
  logic [3:0]      f1, f2, f3;
  logic [1:0]      pl_q;
  logic [1:0][7:0] age;
  logic [3:0]      held;
  logic [1:0]      long_q;

  // Fault seen for four samples; pin age saturates so it never wraps
  always_ff @(posedge CLOCK)
  begin
    f1 <= RST ? 4'h0 : SWITCH_FAULT;
    f2 <= RST ? 4'h0 : f1;
    f3 <= RST ? 4'h0 : f2;
    pl_q <= PIN_LEVEL;
    for (int i = 0; i < 2; i++)
      age[i] <= (RST || PIN_LEVEL[i] != pl_q[i]) ? 8'h00 : age[i] + 8'(age[i] != 8'hFF);
  end

  // Derived flags
  assign held = SWITCH_FAULT & f1 & f2 & f3;
  assign long_q = {age[1] >= 8'(WAKE_FILTER_CYCLES), age[0] >= 8'(WAKE_FILTER_CYCLES)};

  // ------------------------------------------------
  // Properties
  // ------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  reset_quiet_a: assert property (
    $fell(RST) |-> HIGH_SWITCH_DRIVE == 4'h0 && !PULSE_CHANNEL_ONE && PIN_FAIL_SELECT == 2'h0)
    else $error("outputs not quiet after reset");
  restart_off_a: assert property (RESTART_ENTRY |-> ##2 HIGH_SWITCH_DRIVE == 4'h0)
    else $error("drives still on after restart entry");
  fault_clear_a: assert property (
    |held |=> (HIGH_SWITCH_DRIVE & $past(held)) == 4'h0)
    else $error("faulted switch still driven");
  wake_filter_a: assert property ((WAKE_EVENT & ~long_q) == 2'h0)
    else $error("wake event before filter time");
  wake_mode_a: assert property (
    |WAKE_EVENT |-> (WAKE_EVENT & ~PIN_WAKE_ENABLE) == 2'h0 ##1 (WAKE_EVENT & $past(WAKE_EVENT)) == 2'h0)
    else $error("wake event outside wake mode or too long");
  pin_one_mode_a: assert property (
    !$past(RST) |-> $onehot0({PIN_FAIL_SELECT[0], PIN_LOW_SIDE_ON[0], PIN_HIGH_SIDE_ON[0], PIN_WAKE_ENABLE[0]}))
    else $error("pin one mode not unique");
  pin_two_mode_a: assert property (
    !$past(RST) |-> $onehot0({PIN_FAIL_SELECT[1], PIN_LOW_SIDE_ON[1], PIN_HIGH_SIDE_ON[1], PIN_WAKE_ENABLE[1]}))
    else $error("pin two mode not unique");
  sdo_on_a: assert property ($fell(SPI_CSN) |-> ##[1:4] SPI_SDO_OE)
    else $error("data out not enabled in frame");
  sdo_off_a: assert property (SPI_CSN [*5] |-> !SPI_SDO_OE)
    else $error("data out enabled outside frame");

  // Main scenarios reached
  cover property ($rose(SPI_CSN));
  cover property (|WAKE_EVENT);
  cover property (RESTART_ENTRY);
  cover property (|held);
endmodule

`default_nettype wire

//--- dv/hssc_host.sv
// Host model that sends 16-bit register frames
`timescale 1ns/1ns
`default_nettype none

module hssc_host
(
  // Clock
  input  wire logic CLOCK,
  // Frame pins
  output var  logic SPI_CSN,
  output var  logic SPI_CLK,
  output var  logic SPI_SDI,
  input  wire logic SPI_SDO
);
  // Idle: frame deselected, serial clock parked low
  initial
  begin
    SPI_CSN = 1'b1;
    SPI_CLK = 1'b0;
    SPI_SDI = 1'b0;
  end

  // Step n edges, then move just after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge CLOCK);
    #2;
  endtask

  // One frame LSB first; half periods of 5 clocks beat the 4-clock minimum
  // Never asks for tiny duty or cyclic wake without a timer source
  task automatic xfer(input logic [6:0] a, input logic w, input logic [7:0] d,
                      output logic [7:0] r);
    logic [15:0] f;
    f = {d, w, a};
    r = 8'h00;
    SPI_CSN = 1'b0;
    tick(4);
    for (int i = 0; i < 16; i++)
    begin
      SPI_SDI = f[i];
      SPI_CLK = 1'b1;
      tick(5);
      SPI_CLK = 1'b0;
      if (i > 7)
        r[i-8] = SPI_SDO;
      tick(5);
    end
    SPI_CSN = 1'b1;
    SPI_SDI = ~SPI_SDI; // Released line must not keep its last bit
    tick(6);
  endtask
endmodule

`default_nettype wire

//--- dv/tb_high_side_switch_control.sv
// Self-checking bench for the high-side switch control block
`timescale 1ns/1ns
`default_nettype none
`include "hssc_defs.svh"

`define CHK(g, e) \
  begin \
    checked++; \
    if ((g) !== (e)) \
    begin \
      n_mismatch++; \
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e); \
    end \
  end

module tb_high_side_switch_control;
  // ------------------------------------------------
  // Signals
  // ------------------------------------------------
  localparam logic [6:0] a_sd = `HSSC_ADDR_SHUTDOWN;
  localparam logic [6:0] a_sa = `HSSC_ADDR_SRC_A;
  localparam logic [6:0] a_sb = `HSSC_ADDR_SRC_B;
  localparam logic [6:0] a_pc = `HSSC_ADDR_PIN_CFG;
  localparam logic [6:0] a_dy = `HSSC_ADDR_DUTY;
  logic       clock = 1'b0, rst = 1'b1, rst_ent = 1'b0, ov = 1'b0, uv = 1'b0;
  logic       tm1 = 1'b0, tm2 = 1'b0, pw2 = 1'b0, p1, sdo, sdo_oe, csn, sck, sdi;
  logic [3:0] flt = 4'h0, drv;
  logic [1:0] pl = 2'h0, fsel, lo, hi, wen, wk, fod;
  int         n_mismatch = 0, checked = 0;

  always #10 clock = ~clock;

  // Short filter and slot keep the run brief
  hssc_core #(.WAKE_FILTER_CYCLES(4), .PULSE_SLOT_CYCLES(1)) hssc_core_inst (
    .CLOCK(clock), .RST(rst), .RESTART_ENTRY(rst_ent), .SPI_CSN(csn), .SPI_CLK(sck),
    .SPI_SDI(sdi), .SPI_SDO(sdo), .SPI_SDO_OE(sdo_oe), .SUPPLY_OV(ov), .SUPPLY_UV(uv),
    .SWITCH_FAULT(flt), .CYCLIC_TIMER_ONE(tm1), .CYCLIC_TIMER_TWO(tm2),
    .PULSE_CHANNEL_TWO(pw2), .HIGH_SWITCH_DRIVE(drv), .PULSE_CHANNEL_ONE(p1),
    .PIN_LEVEL(pl), .PIN_FAIL_SELECT(fsel), .PIN_LOW_SIDE_ON(lo), .PIN_HIGH_SIDE_ON(hi),
    .PIN_WAKE_ENABLE(wen), .WAKE_EVENT(wk), .FAIL_OUTPUT_DUTY(fod));

  hssc_host hssc_host_inst (.CLOCK(clock), .SPI_CSN(csn), .SPI_CLK(sck), .SPI_SDI(sdi),
    .SPI_SDO(sdo));

  // ------------------------------------------------
  // Helpers
  // ------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] x;
    hssc_host_inst.xfer(a, 1'b1, d, x);
  endtask

  task automatic rchk(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] x;
    hssc_host_inst.xfer(a, 1'b0, 8'h00, x);
    `CHK(x, e)
  endtask

  // Expected {high, low, wake, fail} for a pin code
  function automatic logic [3:0] mode(input logic [2:0] m);
    return {m == 3'h7, m == 3'h6, m == 3'h5, !m[2]};
  endfunction

  task automatic report_and_stop();
    if (n_mismatch == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  task automatic t_regs();
    logic [6:0] ad [5] = '{a_sd, a_sa, a_sb, a_pc, a_dy};
    foreach (ad[i])
      rchk(ad[i], 8'h00);
    wr(a_sd, 8'hFF);
    rchk(a_sd, 8'h70);
    wr(a_sb, 8'hFF);
    rchk(a_sb, 8'h77);
    wr(7'h16, 8'h5A);
    rchk(7'h16, 8'h00);
  endtask

  // Every source code on switch one and four, inputs in both phases;
  // full duty holds pulse one steadily on so code 4 can be told from off
  task automatic t_route();
    logic e;
    wr(a_dy, 8'hFF);
    for (int c = 0; c < 8; c++)
    begin
      wr(a_sa, {5'h00, c[2:0]});
      wr(a_sb, {1'b0, c[2:0], 4'h0});
      for (int k = 0; k < 2; k++)
      begin
        {tm1, tm2, pw2} = k ? 3'b010 : 3'b101;
        tick(2);
        e = (c == 1) | ((c == 2) & tm1) | ((c == 3) & tm2) | (c == 4) | ((c == 5) & pw2);
        `CHK(drv[0], e)
        `CHK(drv[3], e)
      end
    end
  endtask

  // One full period of 255 slots must show exactly duty high slots
  task automatic t_pulse();
    logic [7:0] dv [3] = '{8'h00, 8'hFF, 8'h40};
    logic [8:0] n;
    foreach (dv[j])
    begin
      wr(a_dy, dv[j]);
      n = 9'h000;
      repeat (255)
      begin
        tick(1);
        n = n + 9'(p1);
      end
      `CHK(n, {1'b0, dv[j]})
    end
  endtask

  task automatic t_supply();
    wr(a_sd, 8'h00);
    wr(a_sa, 8'h11);
    ov = 1'b1;
    tick(8);
    `CHK(drv, 4'h0)
    ov = 1'b0;
    tick(8);
    rchk(a_sa, 8'h00);
    wr(a_sd, 8'h10);
    wr(a_sa, 8'h11);
    uv = 1'b1;
    tick(8);
    `CHK(drv, 4'h0)
    uv = 1'b0;
    tick(8);
    `CHK(drv, 4'h3)
    wr(a_sd, 8'h60);
    {ov, uv} = 2'b11;
    tick(8);
    `CHK(drv, 4'h3)
    {ov, uv} = 2'b00;
    flt = 4'h1;
    tick(8);
    `CHK(drv, 4'h2)
    flt = 4'h0;
    rchk(a_sa, 8'h10);
  endtask

  task automatic t_pins();
    logic [3:0] n;
    for (int c = 0; c < 8; c++)
    begin
      wr(a_pc, {c[1:0], 3'(7 - c), c[2:0]});
      `CHK({hi[0], lo[0], wen[0], fsel[0]}, mode(c[2:0]))
      `CHK({hi[1], lo[1], wen[1], fsel[1]}, mode(3'(7 - c)))
      `CHK(fod, c[1:0])
    end
    wr(a_pc, 8'h05);
    for (int k = 0; k < 2; k++)
    begin
      pl = 2'b01; // Short pulse first, then a level that stays
      if (k == 0)
        tick(3);
      if (k == 0)
        pl = 2'b00;
      n = 4'h0;
      repeat (12)
      begin
        tick(1);
        n = n + 4'(wk[0]);
      end
      `CHK(n, 4'(k))
    end
  endtask

  task automatic t_restart();
    wr(a_sd, 8'h50);
    wr(a_sa, 8'h11);
    wr(a_pc, 8'hAC);
    wr(a_dy, 8'h40);
    rst_ent = 1'b1;
    tick(1);
    rst_ent = 1'b0;
    tick(3);
    `CHK(drv, 4'h0)
    rchk(a_sd, 8'h50);
    rchk(a_sa, 8'h00);
    rchk(a_pc, 8'hAC);
    rchk(a_dy, 8'h40);
    rst = 1'b1;
    tick(4);
    rst = 1'b0;
    tick(4);
    rchk(a_pc, 8'h00);
  endtask

  // ------------------------------------------------
  // Run and watchdog
  // ------------------------------------------------
  initial
  begin
    tick(20);
    rst = 1'b0;
    tick(4);
    t_regs();
    t_route();
    t_pulse();
    t_supply();
    t_pins();
    t_restart();
    report_and_stop();
  end

  // About 10,400 cycles expected; cut off well past that
  initial
  begin
    repeat (60000) @(posedge clock);
    n_mismatch++;
    report_and_stop();
  end
endmodule

bind hssc_core hssc_asserts #(.WAKE_FILTER_CYCLES(WAKE_FILTER_CYCLES)) hssc_asserts_inst (
  .CLOCK(CLOCK), .RST(RST), .RESTART_ENTRY(RESTART_ENTRY), .SPI_CSN(SPI_CSN),
  .SWITCH_FAULT(SWITCH_FAULT), .PIN_LEVEL(PIN_LEVEL), .SPI_SDO_OE(SPI_SDO_OE),
  .HIGH_SWITCH_DRIVE(HIGH_SWITCH_DRIVE), .PULSE_CHANNEL_ONE(PULSE_CHANNEL_ONE),
  .PIN_FAIL_SELECT(PIN_FAIL_SELECT), .PIN_LOW_SIDE_ON(PIN_LOW_SIDE_ON),
  .PIN_HIGH_SIDE_ON(PIN_HIGH_SIDE_ON), .PIN_WAKE_ENABLE(PIN_WAKE_ENABLE),
  .WAKE_EVENT(WAKE_EVENT));

`default_nettype wire

//--- hw/hssc_core.sv
// High-side switch control registers, source routing, pin modes and frame port
//
// Notes on behaviour
// - Overvoltage on switch supply turns all switches off unless bit 6 disables it.
// - Undervoltage on switch supply turns all switches off unless bit 5 disables it.
// - Bit 4 set: switches return to prior state when supply fault clears.
// - Reserved bits, including shutdown bits 7 and 3:0, read as zero.
// - Source codes: off, on, timer one, timer two, pulse one, pulse two.
// - Switches one/three in bits 2:0, two/four in bits 6:4 at 0x14/0x15.
// - Overcurrent or overtemperature on a switch clears its source field.
// - Bits 7:6 pick third fail output duty: 20, 10, 5, 2.5 percent.
// - Pin two mode bits 5:3: fail output, off, wake, low on, high on.
// - Pin one mode bits 2:0: fail output, off, wake, low on, high on.
// - Wake inputs pass a 16 us static filter before an event counts.
// - Duty zero is always off, 255 always on, else value over 255.
// - Power-on and soft reset load every register with zero.
// - Restart keeps shutdown bits 6:4, all other bits zero.
// - Restart clears both source registers, turning all switches off.
// - Restart leaves pin configuration and pulse one duty unchanged.
// - Shutdown control at 0x10, pin config at 0x17, duty at 0x18.
`include "hssc_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module hssc_core
  import hssc_pkg::*;
#(
  parameter int WAKE_FILTER_CYCLES = `HSSC_WAKE_FILT_CYC,
  parameter int PULSE_SLOT_CYCLES  = `HSSC_SLOT_CYC
)
(
  // Clock and reset
  input  wire logic       CLOCK,
  input  wire logic       RST,
  // Restart mode entry, one-cycle pulse from the mode controller
  input  wire logic       RESTART_ENTRY,
  // Serial frame port (pins)
  input  wire logic       SPI_CSN,
  input  wire logic       SPI_CLK,
  input  wire logic       SPI_SDI,
  output var  logic       SPI_SDO,
  output var  logic       SPI_SDO_OE,
  // Supply and switch monitors (asynchronous)
  input  wire logic       SUPPLY_OV,
  input  wire logic       SUPPLY_UV,
  input  wire logic [3:0] SWITCH_FAULT,
  // Drive sources from the timer and pulse generators (same clock)
  input  wire logic       CYCLIC_TIMER_ONE,
  input  wire logic       CYCLIC_TIMER_TWO,
  input  wire logic       PULSE_CHANNEL_TWO,
  // Switch drives and pulse one
  output var  logic [3:0] HIGH_SWITCH_DRIVE,
  output var  logic       PULSE_CHANNEL_ONE,
  // Multipurpose pins
  input  wire logic [1:0] PIN_LEVEL,
  output var  logic [1:0] PIN_FAIL_SELECT,
  output var  logic [1:0] PIN_LOW_SIDE_ON,
  output var  logic [1:0] PIN_HIGH_SIDE_ON,
  output var  logic [1:0] PIN_WAKE_ENABLE,
  output var  logic [1:0] WAKE_EVENT,
  output var  logic [1:0] FAIL_OUTPUT_DUTY
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  // Counters are 16 bits wide in the state struct
  if (WAKE_FILTER_CYCLES < 1 || WAKE_FILTER_CYCLES > 65535)
    $error("WAKE_FILTER_CYCLES out of range");
  if (PULSE_SLOT_CYCLES < 1 || PULSE_SLOT_CYCLES > 65535)
    $error("PULSE_SLOT_CYCLES out of range");

  localparam hssc_cnt_t WAKE_LAST = hssc_cnt_t'(WAKE_FILTER_CYCLES - 1);
  localparam hssc_cnt_t SLOT_LAST = hssc_cnt_t'(PULSE_SLOT_CYCLES - 1);
  localparam logic [7:0] PHASE_LAST = 8'(`HSSC_PULSE_SLOTS - 1);
  localparam logic [4:0] FRAME_LEN  = 5'(`HSSC_FRAME_BITS);
  localparam logic [4:0] ADDR_DONE  = 5'h7;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  hssc_state_s s;
  hssc_state_s next_s;

  logic       csn_fall;
  logic       csn_rise;
  logic       sck_rise;
  logic       sck_fall;
  logic       frame_write;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  logic       shut_off;

  // Register read image; absent and reserved bits are zero
  function automatic logic [7:0] read_reg(input hssc_state_s st, input logic [6:0] addr);
    logic [7:0] v;
    v = 8'h00;
    unique case (addr)
      `HSSC_ADDR_SHUTDOWN:
      begin
        v[`HSSC_OV_DIS_BIT]  = st.ov_dis;
        v[`HSSC_UV_DIS_BIT]  = st.uv_dis;
        v[`HSSC_RECOVER_BIT] = st.recover;
      end
      `HSSC_ADDR_SRC_A:
      begin
        v[`HSSC_SRC_LO_LSB +: 3] = st.src[0];
        v[`HSSC_SRC_HI_LSB +: 3] = st.src[1];
      end
      `HSSC_ADDR_SRC_B:
      begin
        v[`HSSC_SRC_LO_LSB +: 3] = st.src[2];
        v[`HSSC_SRC_HI_LSB +: 3] = st.src[3];
      end
      `HSSC_ADDR_PIN_CFG:
      begin
        v[`HSSC_FO_DUTY_LSB +: 2] = st.fo_duty;
        v[`HSSC_PIN_TWO_LSB +: 3] = st.pin_mode[1];
        v[`HSSC_PIN_ONE_LSB +: 3] = st.pin_mode[0];
      end
      `HSSC_ADDR_DUTY:
        v = st.duty;
      default:
        v = 8'h00;
    endcase
    return v;
  endfunction

  // Source selection for one switch; reserved codes drive off
  function automatic logic pick_source(input logic [2:0] code, input logic t1,
                                       input logic t2, input logic p1, input logic p2);
    logic d;
    d = 1'b0;
    unique case (code)
      HSSC_SRC_ON:    d = 1'b1;
      HSSC_SRC_TMR1:  d = t1;
      HSSC_SRC_TMR2:  d = t2;
      HSSC_SRC_PULS1: d = p1;
      HSSC_SRC_PULS2: d = p2;
      default:        d = 1'b0;
    endcase
    return d;
  endfunction

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    // Two-flop synchronisers; stage 0 feeds only stage 1
    next_s.csn_s    = {s.csn_s[1:0], SPI_CSN};
    next_s.sck_s    = {s.sck_s[1:0], SPI_CLK};
    next_s.sdi_s    = {s.sdi_s[0], SPI_SDI};
    next_s.ov_s     = {s.ov_s[0], SUPPLY_OV};
    next_s.uv_s     = {s.uv_s[0], SUPPLY_UV};
    next_s.swf_s[1] = s.swf_s[0];
    next_s.swf_s[0] = SWITCH_FAULT;
    next_s.pin_s[1] = s.pin_s[0];
    next_s.pin_s[0] = PIN_LEVEL;

    // Edges are taken between stage 1 and the extra history stage
    csn_fall = s.csn_s[2] & ~s.csn_s[1];
    csn_rise = ~s.csn_s[2] & s.csn_s[1];
    sck_rise = ~s.sck_s[2] & s.sck_s[1];
    sck_fall = s.sck_s[2] & ~s.sck_s[1];

    // Frame: 7 address bits, access bit, data byte, LSB first
    frame_write = csn_rise && (s.bit_cnt == FRAME_LEN) && s.rx[7];
    wr_addr     = s.rx[6:0];
    wr_data     = s.rx[15:8];
    next_s.sdo_oe = ~s.csn_s[1];
    if (csn_fall)
    begin
      next_s.bit_cnt = 5'h0;
      next_s.tx      = 8'h00;
      next_s.sdo     = 1'b0;
    end
    else if (!s.csn_s[1])
    begin
      // Output changes on rising edges, input sampled on falling edges
      if (sck_rise)
      begin
        next_s.sdo = s.tx[0];
        next_s.tx  = {1'b0, s.tx[7:1]};
      end
      if (sck_fall)
      begin
        next_s.rx = {s.sdi_s[1], s.rx[15:1]};
        if (s.bit_cnt <= FRAME_LEN)
          next_s.bit_cnt = s.bit_cnt + 5'h1;
        // Address complete: load the answer for the data half
        if (s.bit_cnt == ADDR_DONE)
          next_s.tx = read_reg(s, next_s.rx[14:8]);
      end
    end

    // Register writes from a complete 16-bit frame
    if (frame_write)
    begin
      unique case (wr_addr)
        `HSSC_ADDR_SHUTDOWN:
        begin
          next_s.ov_dis  = wr_data[`HSSC_OV_DIS_BIT];
          next_s.uv_dis  = wr_data[`HSSC_UV_DIS_BIT];
          next_s.recover = wr_data[`HSSC_RECOVER_BIT];
        end
        `HSSC_ADDR_SRC_A:
        begin
          next_s.src[0] = wr_data[`HSSC_SRC_LO_LSB +: 3];
          next_s.src[1] = wr_data[`HSSC_SRC_HI_LSB +: 3];
        end
        `HSSC_ADDR_SRC_B:
        begin
          next_s.src[2] = wr_data[`HSSC_SRC_LO_LSB +: 3];
          next_s.src[3] = wr_data[`HSSC_SRC_HI_LSB +: 3];
        end
        `HSSC_ADDR_PIN_CFG:
        begin
          next_s.fo_duty     = wr_data[`HSSC_FO_DUTY_LSB +: 2];
          next_s.pin_mode[1] = wr_data[`HSSC_PIN_TWO_LSB +: 3];
          next_s.pin_mode[0] = wr_data[`HSSC_PIN_ONE_LSB +: 3];
        end
        `HSSC_ADDR_DUTY:
          next_s.duty = wr_data;
        default:
          next_s.duty = next_s.duty;
      endcase
    end

    // Supply shutdown, each cause gated by its disable bit
    shut_off = (s.ov_s[1] & ~s.ov_dis)
             | (s.uv_s[1] & ~s.uv_dis);
    // Without recovery the fields are dropped, so switches stay off;
    // with recovery they are kept and only the drive is gated
    if (shut_off && !s.recover)
      next_s.src = '0;

    // Switch fault clears its field and beats a same-cycle write
    for (int i = 0; i < 4; i++)
    begin
      if (s.swf_s[1][i])
        next_s.src[i] = HSSC_SRC_OFF;
    end

    // Restart entry: source fields cleared, shutdown bits 6:4 kept
    if (RESTART_ENTRY)
      next_s.src = '0;

    // Pulse one: 255 slots per period, high while phase below duty
    if (s.slot_cnt == SLOT_LAST)
    begin
      next_s.slot_cnt = '0;
      next_s.phase    = (s.phase == PHASE_LAST) ? 8'h00 : s.phase + 8'h01;
    end
    else
      next_s.slot_cnt = s.slot_cnt + 16'h0001;
    // Phase never reaches 255, so duty 255 is steady on, duty 0 steady off
    next_s.pulse_out = (s.phase < s.duty);

    // Switch drives from the selected source, gated by supply shutdown
    for (int i = 0; i < 4; i++)
      next_s.drive[i] = ~shut_off & pick_source(s.src[i], CYCLIC_TIMER_ONE,
                          CYCLIC_TIMER_TWO, s.pulse_out, PULSE_CHANNEL_TWO);

    // Multipurpose pin modes and static wake filter
    next_s.fail_duty = s.fo_duty;
    for (int p = 0; p < 2; p++)
    begin
      next_s.wake_event[p] = 1'b0;
      next_s.fail_sel[p]   = ~s.pin_mode[p][2];
      next_s.low_on[p]     = (s.pin_mode[p] == HSSC_PIN_LOW);
      next_s.high_on[p]    = (s.pin_mode[p] == HSSC_PIN_HIGH);
      next_s.wake_en[p]    = (s.pin_mode[p] == HSSC_PIN_WAKE);
      if (s.pin_mode[p] == HSSC_PIN_WAKE)
      begin
        // A level must hold the whole filter time to be accepted
        if (s.pin_s[1][p] != s.wlevel[p])
        begin
          if (s.wcnt[p] == WAKE_LAST)
          begin
            next_s.wlevel[p]     = s.pin_s[1][p];
            next_s.wake_event[p] = 1'b1;
            next_s.wcnt[p]       = '0;
          end
          else
            next_s.wcnt[p] = s.wcnt[p] + 16'h0001;
        end
        else
          next_s.wcnt[p] = '0;
      end
      else
      begin
        // Track silently so enabling wake gives no false event
        next_s.wlevel[p] = s.pin_s[1][p];
        next_s.wcnt[p]   = '0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // State register; reset loads all registers with zero, the chip-select synchroniser with ones
  // ----------------------------------------------------------------------
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      s <= HSSC_RESET;
    else
      s <= next_s;
  end

  // Outputs straight from the state flops
  assign SPI_SDO           = s.sdo;
  assign SPI_SDO_OE        = s.sdo_oe;
  assign HIGH_SWITCH_DRIVE = s.drive;
  assign PULSE_CHANNEL_ONE = s.pulse_out;
  assign PIN_FAIL_SELECT   = s.fail_sel;
  assign PIN_LOW_SIDE_ON   = s.low_on;
  assign PIN_HIGH_SIDE_ON  = s.high_on;
  assign PIN_WAKE_ENABLE   = s.wake_en;
  assign WAKE_EVENT        = s.wake_event;
  assign FAIL_OUTPUT_DUTY  = s.fail_duty;

endmodule

`default_nettype wire

//--- include/hssc_defs.svh
// Constants for the high-side switch control register bank
`ifndef HSSC_DEFS_SVH
`define HSSC_DEFS_SVH

// ----------------------------------------------------------------------
// Register addresses (7-bit frame address)
// ----------------------------------------------------------------------
`define HSSC_ADDR_SHUTDOWN 7'h10
`define HSSC_ADDR_SRC_A    7'h14
`define HSSC_ADDR_SRC_B    7'h15
`define HSSC_ADDR_PIN_CFG  7'h17
`define HSSC_ADDR_DUTY     7'h18

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define HSSC_OV_DIS_BIT    6
`define HSSC_UV_DIS_BIT    5
`define HSSC_RECOVER_BIT   4
`define HSSC_SRC_LO_LSB    0
`define HSSC_SRC_HI_LSB    4
`define HSSC_FO_DUTY_LSB   6
`define HSSC_PIN_TWO_LSB   3
`define HSSC_PIN_ONE_LSB   0
`define HSSC_REG_RESET     8'h00

// ----------------------------------------------------------------------
// Frame layout and timing
// ----------------------------------------------------------------------
`define HSSC_FRAME_BITS    16
`define HSSC_CLOCK_MHZ     50
`define HSSC_WAKE_FILT_NS  16000
`define HSSC_WAKE_FILT_CYC ((`HSSC_WAKE_FILT_NS * `HSSC_CLOCK_MHZ + 999) / 1000)
`define HSSC_PULSE_HZ      200
`define HSSC_PULSE_SLOTS   255
`define HSSC_SLOT_CYC      ((`HSSC_CLOCK_MHZ * 1000000) / (`HSSC_PULSE_HZ * `HSSC_PULSE_SLOTS))

`endif

//--- include/hssc_pkg.sv
// Types shared by the high-side switch control register bank
package hssc_pkg;

  // Source of each high-side switch
  typedef enum logic [2:0] {
    HSSC_SRC_OFF   = 3'h0,
    HSSC_SRC_ON    = 3'h1,
    HSSC_SRC_TMR1  = 3'h2,
    HSSC_SRC_TMR2  = 3'h3,
    HSSC_SRC_PULS1 = 3'h4,
    HSSC_SRC_PULS2 = 3'h5
  } hssc_src_e;

  // Non-fail modes of a multipurpose pin (codes below 4 are fail output)
  typedef enum logic [2:0] {
    HSSC_PIN_OFF   = 3'h4,
    HSSC_PIN_WAKE  = 3'h5,
    HSSC_PIN_LOW   = 3'h6,
    HSSC_PIN_HIGH  = 3'h7
  } hssc_pin_e;

  typedef logic [15:0] hssc_cnt_t;

  // Whole state of the block
  typedef struct packed {
    logic                 ov_dis;
    logic                 uv_dis;
    logic                 recover;
    logic [3:0][2:0]      src;
    logic [1:0]           fo_duty;
    logic [1:0][2:0]      pin_mode;
    logic [7:0]           duty;
    logic [7:0]           phase;
    hssc_cnt_t            slot_cnt;
    logic [2:0]           csn_s;
    logic [2:0]           sck_s;
    logic [1:0]           sdi_s;
    logic [1:0]           ov_s;
    logic [1:0]           uv_s;
    logic [1:0][3:0]      swf_s;
    logic [1:0][1:0]      pin_s;
    logic [4:0]           bit_cnt;
    logic [15:0]          rx;
    logic [7:0]           tx;
    logic [1:0]           wlevel;
    logic [1:0][15:0]     wcnt;
    logic [3:0]           drive;
    logic                 pulse_out;
    logic                 sdo;
    logic                 sdo_oe;
    logic [1:0]           wake_event;
    logic [1:0]           fail_sel;
    logic [1:0]           low_on;
    logic [1:0]           high_on;
    logic [1:0]           wake_en;
    logic [1:0]           fail_duty;
  } hssc_state_s;

  localparam hssc_state_s HSSC_RESET = '{csn_s: 3'h7, default: '0};

endpackage
